// >>> sim/dbs_bus_sizer_tb.sv
// self-checking bench for the bus sizer: write then read back every size,
// offset and port width, checking each bus cycle and each result
// assumes: port model in its own file, design sources under src/
`timescale 1ns/10ps
module dbs_bus_sizer_tb;
   typedef struct {logic [31:0] addr; logic [1:0] size; logic wr; logic [31:0] lanes;} dbs_cyc_t;
   logic clk_sys, rst, reqValid, reqWrite, busy, done, cycleActive, busWrite, busDataOe;
   logic byteOffsetHi, byteOffsetLo, remainingSizeHi, remainingSizeLo, portAckWide, portAckNarrow;
   logic [31:0] reqAddr, reqData, rdData, busDataIn, busDataOut, addr, data;
   logic [31:2] busAddrHigh;
   logic [1:0] reqSize, ackCode;
   logic prevAct;
   int err_count, comparisons;
   dbs_cyc_t cycQ [$];
   dbs_cyc_t c;
   logic [31:0] doneQ [$];

   dbs_bus_sizer dut (.clk_sys, .rst, .reqValid, .reqWrite, .reqAddr, .reqSize, .reqData, .busy, .done,
      .rdData, .busAddrHigh, .byteOffsetHi, .byteOffsetLo, .remainingSizeHi, .remainingSizeLo,
      .cycleActive, .busWrite, .busDataIn, .busDataOut, .busDataOe, .portAckWide, .portAckNarrow);
   dbs_port_model port (.clk_sys, .cycleActive, .busWrite, .lwIndex(busAddrHigh[3:2]),
      .offset({byteOffsetHi, byteOffsetLo}), .sizeCode({remainingSizeHi, remainingSizeLo}),
      .busDataOut, .ackCode, .portData(busDataIn), .portAckWide, .portAckNarrow);

   // free running system clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // lane map per size and offset, two bits of operand byte index per lane
   function automatic logic [31:0] pattern(logic [1:0] sz, logic [1:0] ofs, logic [31:0] op);
      logic [31:0] map;
      logic [7:0] t;
      map = (sz == 2'h0) ? 32'h1B061104 : 32'h6C5B6659;
      t = map[31 - 8 * ofs -: 8];
      if (sz == 2'h1)
         t = 8'hFF;
      if (sz == 2'h2)
         t = ofs[0] ? 8'hAE : 8'hBB;
      for (int i = 0; i < 4; i++)
         pattern[31 - 8 * i -: 8] = op[31 - 8 * t[7 - 2 * i -: 2] -: 8];
   endfunction

   // one request; expected cycles derived from width, offset and bytes left
   task xfer(logic wr, logic [1:0] ack, logic [1:0] sz, logic [31:0] a, logic [31:0] d);
      int n, w, take, k;
      ackCode = ack;
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = a;
      reqSize = sz;
      reqData = wr ? d : ~d;
      n = (sz == 2'h0) ? 4 : int'(sz);
      w = (ack == 2'h3) ? 4 : (ack == 2'h2) ? 2 : 1;
      while (n > 0)
      begin
         cycQ.push_back('{a, 2'(n), wr, pattern(2'(n), a[1:0], d)});
         take = (w == 1) ? 1 : w - int'(a[1:0]) % w;
         take = (take < n) ? take : n;
         a = a + 32'(take);
         n = n - take;
      end
      doneQ.push_back(d);
      // second edge with strobe still high lands while busy and is ignored
      repeat (2) @(posedge clk_sys);
      #1 reqValid = 1'b0;
      check("busy", {31'h0, busy}, 32'h1);
      k = 0;
      while (done !== 1'b1)
      begin
         @(posedge clk_sys);
         #1 k++;
         if (k > 400)
         begin
            err_count++;
            end_sim;
         end
      end
      // checked here, before the next request queues its own cycles
      check("cycles left", 32'(cycQ.size()), 32'h0);
   endtask

   // watcher: checks every cycle start and every completion
   always @(posedge clk_sys)
   begin
      if (cycleActive === 1'b1 && prevAct !== 1'b1)
      begin
         if (cycQ.size() == 0)
            check("extra cycle", 32'h1, 32'h0);
         else
         begin
            c = cycQ.pop_front();
            check("address", {busAddrHigh, byteOffsetHi, byteOffsetLo}, c.addr);
            check("size", {30'h0, remainingSizeHi, remainingSizeLo}, {30'h0, c.size});
            check("enable", {31'h0, busDataOe}, {31'h0, c.wr});
            check("direction", {31'h0, busWrite}, {31'h0, c.wr});
            if (c.wr)
               check("lanes", busDataOut, c.lanes);
         end
      end
      if (done === 1'b1)
      begin
         check("operand", rdData, (doneQ.size() > 0) ? doneQ.pop_front() : 32'hDEADBEEF);
      end
      prevAct <= cycleActive;
   end

   // hang guard
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      err_count++;
      end_sim;
   end

   // main sequence: every width, size and offset, write then read back
   initial
   begin
      rst = 1'b1;
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 32'h0;
      reqSize = 2'h0;
      reqData = 32'h0;
      ackCode = 2'h3;
      prevAct = 1'b0;
      err_count = 0;
      comparisons = 0;
      void'($urandom(32'h83b2c3d0));
      repeat (3) @(posedge clk_sys);
      #1 rst = 1'b0;
      check("idle", {30'h0, busy, cycleActive}, 32'h0);
      for (int ack = 1; ack < 4; ack++)
         for (int sz = 0; sz < 4; sz++)
            for (int ofs = 0; ofs < 4; ofs++)
            begin
               addr = ($urandom() & 32'hFFFFFFF0) | 32'(ofs);
               data = $urandom();
               if (sz != 0)
                  data = data & ((32'h1 << (8 * sz)) - 32'h1);
               xfer(1'b1, 2'(ack), 2'(sz), addr, data);
               xfer(1'b0, 2'(ack), 2'(sz), addr, data);
            end
      repeat (4) @(posedge clk_sys);
      end_sim;
   end
endmodule // dbs_bus_sizer_tb

// >>> sim/dbs_port_model.sv
// behavioural 8, 16 or 32 bit port on the far side of the byte steering block
// assumes: ack code chosen by the bench only while the block is idle
`timescale 1ns/10ps
module dbs_port_model (
   // clock
   input wire logic clk_sys,
   // cycle seen on the pins
   input wire logic cycleActive,
   input wire logic busWrite,
   input wire logic [1:0] lwIndex,
   input wire logic [1:0] offset,
   input wire logic [1:0] sizeCode,
   input wire logic [31:0] busDataOut,
   // port width as its ack code
   input wire logic [1:0] ackCode,
   // answer
   output logic [31:0] portData,
   output logic portAckWide,
   output logic portAckNarrow
);
   logic [7:0] mem [0:15];
   logic [3:0] a;
   int n, w, take, lane;

   // one pass per bus cycle; random wait states stretch the handshake
   initial
   begin
      portData = 32'h5A5A5A5A;
      {portAckWide, portAckNarrow} = 2'h0;
      foreach (mem[i]) mem[i] = 8'h00;
      forever
      begin
         @(posedge clk_sys);
         #1;
         if (cycleActive === 1'b1)
         begin
            a = {lwIndex, offset};
            n = (sizeCode == 2'h0) ? 4 : int'(sizeCode);
            w = (ackCode == 2'h3) ? 4 : (ackCode == 2'h2) ? 2 : 1;
            // lanes fixed by port width, unused lanes toggle garbage
            lane = (w == 1) ? 0 : int'(a) % w;
            take = (n < w - lane) ? n : w - lane;
            portData = ~portData;
            // read bytes laid out from the port's own base lane
            if (busWrite !== 1'b1)
               for (int k = 0; k < w; k++)
                  portData[31 - 8 * k -: 8] = mem[(a & ~4'(w - 1)) + 4'(k)];
            // data stands two to five clocks before ack so it survives the sync flops
            repeat (2 + $urandom_range(3, 0)) @(posedge clk_sys);
            #1;
            // the port latches only the lanes it owns
            if (busWrite === 1'b1)
               for (int k = 0; k < take; k++)
                  mem[a + 4'(k)] = busDataOut[31 - 8 * (lane + k) -: 8];
            // ack code reports the port width
            {portAckWide, portAckNarrow} = ackCode;
            while (cycleActive === 1'b1)
            begin
               @(posedge clk_sys);
               #1;
            end
            {portAckWide, portAckNarrow} = 2'h0;
            portData = ~portData;
         end
      end
   end
endmodule // dbs_port_model

// >>> src/dbs_bus_sizer.sv
// dynamic bus sizing sequencer with read and write byte steering
// assumes: port holds read data stable while it acknowledges, and drops
// its acknowledge before a new cycle starts
//
// Summary of operation
// R01: low two address outputs carry the byte offset from the long-word base.
// R02: a 32-bit port returns offset bytes zero to three on lanes top to bottom.
// R03: a 16-bit port returns even bytes on the top lane, odd on the second.
// R04: read takes first byte at offset lane, later bytes lower, up to port width.
// R05: single remaining byte is driven on all four lanes.
// R06: word write ignores offset bit one and duplicates bytes per offset bit zero.
// R07: long or three-byte write starts at addressed lane and duplicates upward.
// R08: some patterns drive a filler byte that no port uses.
// R09: aligned long write drives all four operand bytes in the first cycle.
// R10: a 16-bit port ack on an aligned long write leads to a word cycle at offset two.
// R11: that second cycle puts the two low operand bytes on the upper half.
// R12: word write to an 8-bit port takes two cycles, size word then byte.
// R13: size outputs give bytes still to move: 01, 10, 11, 00 for four.
// R14: port acknowledge codes: none waits, narrow 8, wide 16, both 32 bits.
// R15: 16-bit ports sit on the upper half, 8-bit ports on the top lane.
// R16: each ack advances address and shrinks size until no bytes remain.
`timescale 1ns/10ps
`include "dbs_params.svh"
module dbs_bus_sizer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // user request
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [31:0] reqAddr,
   input wire logic [1:0] reqSize,
   input wire logic [31:0] reqData,
   // user answer
   output logic busy,
   output logic done,
   output logic [31:0] rdData,
   // external address and size
   output logic [31:2] busAddrHigh,
   output logic byteOffsetHi,
   output logic byteOffsetLo,
   output logic remainingSizeHi,
   output logic remainingSizeLo,
   output logic cycleActive,
   output logic busWrite,
   // external data bus, two-way
   input wire logic [31:0] busDataIn,
   output logic [31:0] busDataOut,
   output logic busDataOe,
   // port acknowledge pins
   input wire logic portAckWide,
   input wire logic portAckNarrow
);
   dbs_pkg::dbs_state_t state_r, state_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [1:0] remain_r, remain_nxt;
   logic [31:0] operand_r, operand_nxt;
   logic write_r, write_nxt;
   logic last_r, last_nxt;
   logic active_r, active_nxt;
   logic oe_r, oe_nxt;
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   logic [31:0] dataOut_r;
   logic [31:0] muxOut;
   logic [1:0] ackMeta_r, ackSync_r;
   logic [31:0] dataMeta_r, dataSync_r;
   logic [2:0] remainCount;
   logic [2:0] takeCount;
   logic ackSeen;

   // pins are asynchronous; data travels with the ack so both arrive aligned
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         ackMeta_r <= 2'h0;
         ackSync_r <= 2'h0;
         dataMeta_r <= 32'h0;
         dataSync_r <= 32'h0;
      end
      else
      begin
         ackMeta_r <= {portAckWide, portAckNarrow};
         ackSync_r <= ackMeta_r;
         dataMeta_r <= busDataIn;
         dataSync_r <= dataMeta_r;
      end
   end

   assign ackSeen = (state_r == dbs_pkg::DBS_RUN) && (ackSync_r != `DBS_ACK_WAIT);

   // remaining bytes and bytes the reported port width takes this cycle
   always_comb
   begin
      remainCount = (remain_r == `DBS_SIZE_LONG) ? 3'h4 : {1'b0, remain_r};
      takeCount = 3'h4 - {1'b0, addr_r[1:0]};
      // R10 R12 R14: ack width sets bytes taken
      case (ackSync_r)
         `DBS_ACK_8: takeCount = 3'h1;
         `DBS_ACK_16: takeCount = addr_r[0] ? 3'h1 : 3'h2;
         default: takeCount = 3'h4 - {1'b0, addr_r[1:0]};
      endcase
      if (takeCount > remainCount)
         takeCount = remainCount;
   end

   // sequencer next state; a long word is always tried as if the port were 32 bits
   always_comb
   begin
      logic [2:0] lane;
      logic [2:0] idx;
      lane = 3'h0;
      idx = 3'h0;
      state_nxt = state_r;
      addr_nxt = addr_r;
      remain_nxt = remain_r;
      operand_nxt = operand_r;
      write_nxt = write_r;
      last_nxt = last_r;
      active_nxt = active_r;
      oe_nxt = oe_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      case (state_r)
         dbs_pkg::DBS_IDLE:
         begin
            if (reqValid)
            begin
               state_nxt = dbs_pkg::DBS_RUN;
               addr_nxt = reqAddr;
               remain_nxt = reqSize;
               operand_nxt = reqWrite ? reqData : 32'h0;
               write_nxt = reqWrite;
               last_nxt = 1'b0;
               active_nxt = 1'b1;
               oe_nxt = reqWrite;
               busy_nxt = 1'b1;
            end
         end
         dbs_pkg::DBS_RUN:
         begin
            if (ackSeen)
            begin
               // R04: steer read lanes into operand
               if (!write_r)
               begin
                  for (int j = 0; j < 4; j++)
                  begin
                     if (3'(j) < takeCount)
                     begin
                        case (ackSync_r)
                           `DBS_ACK_8: lane = 3'h0;
                           `DBS_ACK_16: lane = {2'h0, addr_r[0]} + 3'(j);
                           default: lane = {1'b0, addr_r[1:0]} + 3'(j);
                        endcase
                        idx = 3'h4 - remainCount + 3'(j);
                        operand_nxt[8 * (3 - idx[1:0]) +: 8] = dataSync_r[8 * (3 - lane[1:0]) +: 8];
                     end
                  end
               end
               // R16: advance address, shrink size
               addr_nxt = addr_r + {29'h0, takeCount};
               remain_nxt = 2'(remainCount - takeCount);
               last_nxt = (takeCount == remainCount);
               active_nxt = 1'b0;
               oe_nxt = 1'b0;
               state_nxt = dbs_pkg::DBS_RELEASE;
            end
         end
         dbs_pkg::DBS_RELEASE:
         begin
            // wait for ack release so one ack never ends two cycles
            if (ackSync_r == `DBS_ACK_WAIT)
            begin
               if (last_r)
               begin
                  state_nxt = dbs_pkg::DBS_IDLE;
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
               else
               begin
                  state_nxt = dbs_pkg::DBS_RUN;
                  active_nxt = 1'b1;
                  oe_nxt = write_r;
               end
            end
         end
         default: state_nxt = dbs_pkg::DBS_IDLE;
      endcase
   end

   // lane pattern is built from next values so the data register matches the address
   dbs_write_mux uWriteMux (
      .sizeCode(remain_nxt),
      .byteOffset(addr_nxt[1:0]),
      .operand(operand_nxt),
      .laneData(muxOut)
   );

   // sequencer and output registers
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= dbs_pkg::DBS_IDLE;
         addr_r <= 32'h0;
         remain_r <= `DBS_SIZE_LONG;
         operand_r <= 32'h0;
         write_r <= 1'b0;
         last_r <= 1'b0;
         active_r <= 1'b0;
         oe_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         dataOut_r <= 32'h0;
      end
      else
      begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         remain_r <= remain_nxt;
         operand_r <= operand_nxt;
         write_r <= write_nxt;
         last_r <= last_nxt;
         active_r <= active_nxt;
         oe_r <= oe_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         dataOut_r <= muxOut;
      end
   end

   // R01: offset on low address bits
   assign byteOffsetHi = addr_r[1];
   assign byteOffsetLo = addr_r[0];
   assign busAddrHigh = addr_r[31:2];
   // R13: size outputs show remaining bytes
   assign remainingSizeHi = remain_r[1];
   assign remainingSizeLo = remain_r[0];
   assign cycleActive = active_r;
   assign busWrite = write_r;
   assign busDataOut = dataOut_r;
   assign busDataOe = oe_r;
   assign busy = busy_r;
   assign done = done_r;
   assign rdData = operand_r;

   // steps of the sizing sequence
   sequence seqWideAckOnAlignedLong;
      ackSeen && write_r && remain_r == `DBS_SIZE_LONG && addr_r[1:0] == `DBS_OFS_0 && ackSync_r == `DBS_ACK_16;
   endsequence
   sequence seqWordHalfCycle;
      remain_r == `DBS_SIZE_WORD && addr_r[1:0] == `DBS_OFS_2;
   endsequence

   AST_OFFSET_PINS: assert property (@(posedge clk_sys) disable iff (rst) // R01
      cycleActive |-> {byteOffsetHi, byteOffsetLo} == addr_r[1:0] && ($stable(addr_r) || !$past(cycleActive)))
      else $error("offset pins moved during a cycle");
   AST_BYTE_ALL_LANES: assert property (@(posedge clk_sys) disable iff (rst) // R05
      cycleActive && busWrite && remain_r == `DBS_SIZE_BYTE |-> busDataOut == {4{operand_r[7:0]}})
      else $error("byte write not on all lanes");
   AST_WORD_EVEN_PATTERN: assert property (@(posedge clk_sys) disable iff (rst) // R06
      cycleActive && busWrite && remain_r == `DBS_SIZE_WORD && !addr_r[0]
      |-> busDataOut == {2{operand_r[15:0]}})
      else $error("word write pattern wrong");
   AST_ALIGNED_LONG: assert property (@(posedge clk_sys) disable iff (rst) // R09
      cycleActive && busWrite && remain_r == `DBS_SIZE_LONG && addr_r[1:0] == `DBS_OFS_0 |-> busDataOut == operand_r)
      else $error("aligned long write not whole operand");
   AST_WIDE_SPLIT: assert property (@(posedge clk_sys) disable iff (rst) // R10
      seqWideAckOnAlignedLong |=> !cycleActive ##0 seqWordHalfCycle)
      else $error("no word cycle at offset two after 16-bit ack");
   AST_LOW_HALF_UP: assert property (@(posedge clk_sys) disable iff (rst) // R11
      (cycleActive && busWrite) and seqWordHalfCycle |-> busDataOut[31:16] == operand_r[15:0])
      else $error("low bytes not on upper half");
   AST_BYTE_PORT_WORD: assert property (@(posedge clk_sys) disable iff (rst) // R12
      ackSeen && remain_r == `DBS_SIZE_WORD && !addr_r[0] && ackSync_r == `DBS_ACK_8
      |=> remain_r == `DBS_SIZE_BYTE && !last_r)
      else $error("word to byte port not split in two");
   AST_READ_TOP_LANE: assert property (@(posedge clk_sys) disable iff (rst) // R04
      ackSeen && !write_r && ackSync_r == `DBS_ACK_8 && remain_r == `DBS_SIZE_BYTE
      |=> operand_r[7:0] == $past(dataSync_r[31:24]))
      else $error("8-bit read not from top lane");
   AST_FINISH: assert property (@(posedge clk_sys) disable iff (rst) // R16
      ackSeen && ackSync_r == `DBS_ACK_32 && remain_r == `DBS_SIZE_LONG && addr_r[1:0] == `DBS_OFS_0
      |=> last_r && addr_r == $past(addr_r) + 32'h4)
      else $error("aligned long to 32-bit port not finished in one cycle");
endmodule // dbs_bus_sizer

// >>> src/dbs_params.svh
// constants for the dynamic bus sizing byte steering block
// assumes: included by bare name from the design modules only, not from the package
`ifndef DBS_PARAMS_SVH
`define DBS_PARAMS_SVH

// remaining size codes driven on the two size outputs
`define DBS_SIZE_LONG 2'h0
`define DBS_SIZE_BYTE 2'h1
`define DBS_SIZE_WORD 2'h2
`define DBS_SIZE_THREE 2'h3

// two-bit port acknowledge codes, wide bit first
`define DBS_ACK_WAIT 2'h0
`define DBS_ACK_8 2'h1
`define DBS_ACK_16 2'h2
`define DBS_ACK_32 2'h3

// byte offsets from the long-word base
`define DBS_OFS_0 2'h0
`define DBS_OFS_1 2'h1
`define DBS_OFS_2 2'h2
`define DBS_OFS_3 2'h3

`endif

// >>> src/dbs_pkg.sv
// types shared by the byte steering block
// assumes: nothing beyond the constants header
package dbs_pkg;
   // bus cycle sequencer states
   typedef enum logic [1:0] {DBS_IDLE, DBS_RUN, DBS_RELEASE} dbs_state_t;
endpackage

// >>> src/dbs_write_mux.sv
// write multiplexer: places operand bytes on the four data lanes
// assumes: purely combinational, fed from the caller's next-state values so the
// caller can register the lane pattern together with the address
`timescale 1ns/10ps
`include "dbs_params.svh"
module dbs_write_mux (
   // cycle description
   input wire logic [1:0] sizeCode,
   input wire logic [1:0] byteOffset,
   // operand, msb byte first
   input wire logic [31:0] operand,
   // lane pattern, top lane first
   output logic [31:0] laneData
);
   logic [7:0] operandByteMsb;
   logic [7:0] operandByteSecond;
   logic [7:0] operandByteThird;
   logic [7:0] operandByteLsb;

   assign operandByteMsb = operand[31:24];
   assign operandByteSecond = operand[23:16];
   assign operandByteThird = operand[15:8];
   assign operandByteLsb = operand[7:0];

   // lane pattern by remaining size and offset; duplicates let any port width find its bytes
   always_comb
   begin
      laneData = operand;
      case (sizeCode)
         // R05: byte on all lanes
         `DBS_SIZE_BYTE: laneData = {4{operandByteLsb}};
         // R06 R11: word ignores offset bit one
         `DBS_SIZE_WORD:
         begin
            if (byteOffset[0])
               laneData = {operandByteThird, operandByteThird, operandByteLsb, operandByteThird};
            else
               laneData = {operandByteThird, operandByteLsb, operandByteThird, operandByteLsb};
         end
         // R07: three bytes from addressed lane
         `DBS_SIZE_THREE:
         begin
            case (byteOffset)
               // R08: filler byte on low lane
               `DBS_OFS_0: laneData = {operandByteSecond, operandByteThird, operandByteLsb, operandByteMsb};
               `DBS_OFS_1: laneData = {operandByteSecond, operandByteSecond, operandByteThird, operandByteLsb};
               `DBS_OFS_2: laneData = {operandByteSecond, operandByteThird, operandByteSecond, operandByteThird};
               // R08: filler byte unused by ports
               default: laneData = {operandByteSecond, operandByteSecond, operandByteThird, operandByteSecond};
            endcase
         end
         // R07: long word from addressed lane
         default:
         begin
            case (byteOffset)
               // R09: aligned long drives all bytes
               `DBS_OFS_0: laneData = operand;
               `DBS_OFS_1: laneData = {operandByteMsb, operandByteMsb, operandByteSecond, operandByteThird};
               `DBS_OFS_2: laneData = {operandByteMsb, operandByteSecond, operandByteMsb, operandByteSecond};
               // R08: filler byte in offset three
               default: laneData = {operandByteMsb, operandByteMsb, operandByteSecond, operandByteMsb};
            endcase
         end
      endcase
   end
endmodule // dbs_write_mux
